// *** sim/dif_checker.sv ***
// Pin-level assertions for the input elastic buffer.
// Bound to dif_top; sees only its ports.
`default_nettype none
module dif_checker (
  input wire logic clk,
  input wire logic resetn,
  input wire logic conversion_clock,
  input wire logic [1:0] interp_sel,
  input wire logic reference_sync_input,
  input wire logic [7:0] reg_addr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic out_valid,
  input wire logic fifo_warning
);
  import dif_pkg::*;
  default clocking @(posedge clk);
  endclocking
  default disable iff (!resetn);
  logic rd_st, rd_lvl, rd_off;
  assign rd_st = reg_rd && reg_addr == DIF_ADDR_INIT_STATUS;
  assign rd_lvl = reg_rd && reg_addr == DIF_ADDR_LEVEL;
  assign rd_off = reg_rd && reg_addr == DIF_ADDR_PHASE_OFFSET;
  // ====================
  // Register readback
  property p_lvl_therm;
    rd_lvl |=> !reg_rdata[7] && ((reg_rdata + 8'h01) & reg_rdata) == 8'h00;
  endproperty
  a_lvl_therm: assert property (p_lvl_therm)
    else $error("level not thermometer");
  property p_warn_bit;
    rd_st |=> reg_rdata[DIF_ST_WARN_BIT] == $past(fifo_warning);
  endproperty
  a_warn_bit: assert property (p_warn_bit)
    else $error("status warning differs from pin");
  property p_ack;
    rd_st |=> reg_rdata[DIF_ST_ACK_BIT] == reg_rdata[DIF_ST_REQ_BIT];
  endproperty
  a_ack: assert property (p_ack)
    else $error("ack does not follow request");
  property p_one_method;
    rd_st |=> !(reg_rdata[DIF_ST_BY_MARKER_BIT] && reg_rdata[DIF_ST_BY_SERIAL_BIT]);
  endproperty
  a_one_method: assert property (p_one_method)
    else $error("two init methods reported");
  property p_offset_rb;
    rd_off |=> reg_rdata[7:3] == 5'h00;
  endproperty
  a_offset_rb: assert property (p_offset_rb)
    else $error("offset above three bits");
  // ====================
  // Read side pacing
  property p_valid_pulse;
    out_valid |=> !out_valid;
  endproperty
  a_valid_pulse: assert property (p_valid_pulse)
    else $error("valid longer than one cycle");
  property p_valid_cause;
    out_valid |-> $past(conversion_clock, 2) && !$past(conversion_clock, 3);
  endproperty
  a_valid_cause: assert property (p_valid_cause)
    else $error("valid without clock rise");
  property p_tick_out;
    $rose(conversion_clock) && interp_sel == 2'h0 && !reference_sync_input |-> ##2 out_valid;
  endproperty
  a_tick_out: assert property (p_tick_out)
    else $error("no word after rate tick");
  c_valid: cover property (out_valid);
  c_warn: cover property ($rose(fifo_warning));
  c_lvl4: cover property (rd_lvl ##1 reg_rdata == 8'h0f);
endmodule
bind dif_top dif_checker u_chk (
  .clk, .resetn, .conversion_clock, .interp_sel, .reference_sync_input,
  .reg_addr, .reg_rd, .reg_rdata, .out_valid, .fifo_warning
);
`default_nettype wire

// *** sim/dif_source.sv ***
// Behavioural data source on the strobed parallel port.
// Tasks are called from the bench, starting at a clk edge.
`default_nettype none
module dif_source (
  input wire logic clk,
  input wire logic [1:0] bus_mode,
  output logic data_strobe_clock,
  output logic [dif_pkg::DIF_BUS_W-1:0] data_bus,
  output logic channel_marker
);
  import dif_pkg::*;
  initial begin
    data_strobe_clock = 1'b0;
    data_bus = '0;
    channel_marker = 1'b0;
  end
  // ====================
  // One strobe period
  // held across fall
  task automatic fall(input logic [31:0] d, input logic m);
    @(posedge clk);
    data_bus <= d;
    channel_marker <= m;
    data_strobe_clock <= 1'b1;
    repeat (2) @(posedge clk);
    data_strobe_clock <= 1'b0;
    repeat (2) @(posedge clk);
    // Hold over: show no stale word
    data_bus <= ~d;
  endtask
  task automatic load(input logic [15:0] i, input logic [15:0] q);
    case (bus_mode)
      DIF_MODE_DUAL: fall({i, q}, 1'b0);
      DIF_MODE_WORD: begin
        fall({16'h0, i}, 1'b1);
        fall({16'h0, q}, 1'b0);
      end
      default: begin
        fall({24'h0, i[15:8]}, 1'b1);
        fall({24'h0, i[7:0]}, 1'b1);
        fall({24'h0, q[15:8]}, 1'b0);
        fall({24'h0, q[7:0]}, 1'b0);
      end
    endcase
  endtask
  task automatic mark();
    int n;
    n = bus_mode == DIF_MODE_DUAL ? DIF_LOAD_DUAL :
        bus_mode == DIF_MODE_WORD ? DIF_LOAD_WORD : DIF_LOAD_BYTE;
    repeat (n) fall(32'h0, 1'b1);
    channel_marker <= 1'b0;
  endtask
endmodule
`default_nettype wire

// *** sim/test_dif_input_fifo_alignment.sv ***
// Self-checking bench for the input elastic buffer.
// Needs dif_top, dif_source and the bound checker.
`default_nettype none
module test_dif_input_fifo_alignment;
  timeunit 1ns;
  timeprecision 1ps;
  import dif_pkg::*;
  typedef struct packed {logic [7:0] a; logic [7:0] d; logic [7:0] e;} dif_row_t;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic conv = 1'b0;
  logic sync = 1'b0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [1:0] bus_mode = 2'h0;
  logic [1:0] interp_sel = 2'h0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic strobe, marker, out_valid, fifo_warning;
  logic [DIF_BUS_W-1:0] data_bus;
  logic [7:0] reg_rdata;
  logic [DIF_WORD_W-1:0] i_out, q_out;
  logic [31:0] got [$];
  int error_cnt = 0;
  int total_checks = 0;
  // Write, then expect readback
  dif_row_t rows [7] = '{'{8'h10, 8'h48, 8'h48}, '{8'h10, 8'h00, 8'h00},
    '{8'h17, 8'h00, 8'h00}, '{8'h17, 8'hff, 8'h07}, '{8'h19, 8'hff, 8'h00},
    '{8'h33, 8'h5a, 8'h00}, '{8'h17, 8'h07, 8'h07}};
  initial begin
    forever #20 clk = ~clk;
  end
  dif_top u_dut (.clk(clk), .resetn(resetn), .data_strobe_clock(strobe),
    .data_bus(data_bus), .channel_marker(marker), .bus_mode(bus_mode),
    .conversion_clock(conv), .interp_sel(interp_sel), .reference_sync_input(sync),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .i_out(i_out), .q_out(q_out), .out_valid(out_valid),
    .fifo_warning(fifo_warning));
  dif_source u_src (.clk(clk), .bus_mode(bus_mode), .data_strobe_clock(strobe),
    .data_bus(data_bus), .channel_marker(marker));
  always @(posedge clk) begin
    if (out_valid === 1'b1) begin
      got.push_back({i_out, q_out});
    end
  end
  // ====================
  // Shared tasks
  task automatic chk_reg(input string n, input logic [7:0] e, input logic [7:0] s);
    total_checks++;
    if (s !== e) begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic chk_out(input string n, input logic [31:0] e, input logic [31:0] s);
    total_checks++;
    if (s !== e) begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    repeat (2) @(posedge clk);
    chk_reg($sformatf("reg %h", a), e, reg_rdata);
  endtask
  task automatic tick(input int n);
    repeat (n) begin
      conv <= 1'b1;
      repeat (2) @(posedge clk);
      conv <= 1'b0;
      repeat (2) @(posedge clk);
    end
  endtask
  task automatic do_reset();
    resetn <= 1'b0;
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
  endtask
  task automatic results();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    #100us;
    error_cnt++;
    results();
  end
  // ====================
  // Main sequence
  initial begin
    do_reset();
    foreach (rows[k]) begin
      wr(rows[k].a, rows[k].d);
      rchk(rows[k].a, rows[k].e);
    end
    do_reset();
    rchk(8'h10, 8'h00);
    rchk(8'h17, 8'h04);
    rchk(8'h18, 8'h00);
    for (int k = 1; k <= 8; k++) begin
      u_src.load({8'ha0, 8'(k)}, {8'h50, 8'(k)});
      rchk(8'h19, (8'h01 << (k % 8)) - 8'h01);
      chk_reg("warn", 8'(k == 1 || k == 7), {7'h0, fifo_warning});
    end
    tick(10); // drain with no writer
    repeat (3) @(posedge clk);
    chk_out("count", 32'd10, 32'(got.size()));
    foreach (got[j]) begin
      chk_out("word", {8'ha0, 8'(j % 8 + 1), 8'h50, 8'(j % 8 + 1)}, got[j]);
    end
    for (int s = 0; s < 4; s++) begin
      got.delete();
      interp_sel <= 2'(s);
      tick(8);
      repeat (3) @(posedge clk);
      chk_out("ticks", 32'(8 >> s), 32'(got.size()));
    end
    interp_sel <= 2'h0;
    for (int m = 0; m < 3; m++) begin
      bus_mode <= 2'(m);
      do_reset();
      u_src.load(16'hc3a5, 16'h5a3c ^ 16'(m));
      got.delete();
      tick(1);
      repeat (3) @(posedge clk);
      chk_out("route", {16'hc3a5, 16'h5a3c ^ 16'(m)}, got[0]);
    end
    do_reset();
    wr(8'h17, 8'h05);
    wr(8'h18, 8'h02);
    rchk(8'h18, 8'h27);
    wr(8'h18, 8'h00);
    rchk(8'h18, 8'h21);
    rchk(8'h19, 8'h1f);
    bus_mode <= 2'h1;
    do_reset();
    wr(8'h10, 8'h80);
    tick(3);
    u_src.mark();
    rchk(8'h19, 8'h01);
    rchk(8'h18, 8'h91);
    sync <= 1'b1;
    tick(1);
    sync <= 1'b0;
    rchk(8'h19, 8'h0f);
    wr(8'h10, 8'h88);
    conv <= 1'b1;
    repeat (2) @(posedge clk);
    sync <= 1'b1;
    conv <= 1'b0;
    repeat (2) @(posedge clk);
    sync <= 1'b0;
    rchk(8'h19, 8'h0f);
    wr(8'h10, 8'hc0);
    wr(8'h17, 8'h06);
    // Marker low on a strobe fall rearms the marker count
    u_src.load(16'h1234, 16'h5678);
    tick(3); // level kept at two
    u_src.mark();
    rchk(8'h19, 8'h03);
    tick(5);
    rchk(8'h19, 8'h3f);
    // Sync disabled: marker reset is relative
    wr(8'h17, 8'h03);
    wr(8'h10, 8'h00);
    u_src.load(16'h2345, 16'h6789);
    tick(2);
    u_src.mark();
    rchk(8'h19, 8'h1f);
    tick(6);
    rchk(8'h19, 8'h07);
    rchk(8'h18, 8'h11);
    results();
  end
endmodule
`default_nettype wire

// *** verilog/dif_pkg.sv ***
// Constants, register map and field layout of the input elastic buffer.
// Assumes one 25 MHz system clock; every pin is sampled synchronously to it.
// Function
// - Sample bus and marker on strobe fall.
// - Two sixteen-bit channels, eight entries deep.
// - Write at write pointer, then advance.
// - Read at read pointer each data-rate cycle.
// - Serial-port pointer reset is always relative.
// - Marker reset relative, absolute in FIFO-rate.
// - Relative reset loads offset at read zero.
// - Acknowledge follows request; controller checks it.
// - Data-rate mode marker loads start level.
// - FIFO-rate mode: sync clears read pointer.
// - Sync sampling edge selectable by control.
// - FIFO-rate marker loads offset immediately.
// - Status reports init method and success.
// - Status MSB warns at level 1/7.
// - Level register is thermometer of level.
// - Word and byte modes: marker high routes to I, low Q.
`default_nettype none

package dif_pkg;

  // ==========================================================
  // Geometry
  localparam int DIF_WORD_W = 16;
  localparam int DIF_DEPTH = 8;
  localparam int DIF_PTR_W = 3;
  localparam int DIF_BUS_W = 32;

  // ==========================================================
  // Register offsets
  localparam logic [7:0] DIF_ADDR_SYNC_CONTROL = 8'h10;
  localparam logic [7:0] DIF_ADDR_PHASE_OFFSET = 8'h17;
  localparam logic [7:0] DIF_ADDR_INIT_STATUS = 8'h18;
  localparam logic [7:0] DIF_ADDR_LEVEL = 8'h19;

  // ==========================================================
  // Field positions
  localparam int DIF_SYNC_EDGE_BIT = 3;
  localparam int DIF_SYNC_MODE_BIT = 6;
  localparam int DIF_SYNC_EN_BIT = 7;
  localparam int DIF_ST_OK_BIT = 0;
  localparam int DIF_ST_REQ_BIT = 1;
  localparam int DIF_ST_ACK_BIT = 2;
  localparam int DIF_ST_BY_MARKER_BIT = 4;
  localparam int DIF_ST_BY_SERIAL_BIT = 5;
  localparam int DIF_ST_WARN_BIT = 7;

  // ==========================================================
  // Reset values
  localparam logic [7:0] DIF_SYNC_CONTROL_RST = 8'h00;
  localparam logic [2:0] DIF_PHASE_OFFSET_RST = 3'h4;

  // ==========================================================
  // Levels that raise the warning flag
  localparam logic [2:0] DIF_LEVEL_LOW = 3'h1;
  localparam logic [2:0] DIF_LEVEL_HIGH = 3'h7;

  // ==========================================================
  // Bus modes and interpolation ratios
  typedef enum logic [1:0] {
    DIF_MODE_DUAL = 2'h0,
    DIF_MODE_WORD = 2'h1,
    DIF_MODE_BYTE = 2'h2
  } dif_mode_t;

  typedef enum logic [1:0] {
    DIF_INTERP_1 = 2'h0,
    DIF_INTERP_2 = 2'h1,
    DIF_INTERP_4 = 2'h2,
    DIF_INTERP_8 = 2'h3
  } dif_interp_t;

  // Strobe periods in one full I/Q load, per bus mode
  localparam logic [2:0] DIF_LOAD_DUAL = 3'h1;
  localparam logic [2:0] DIF_LOAD_WORD = 3'h2;
  localparam logic [2:0] DIF_LOAD_BYTE = 3'h4;

endpackage

`default_nettype wire

// *** verilog/dif_store.sv ***
// Eight-entry, two-channel storage of the input buffer.
// Assumes one writer and one reader driven from the same clock.
`default_nettype none

module dif_store (
  input wire logic clk,
  input wire logic resetn,
  input wire logic wr_en,
  input wire logic [dif_pkg::DIF_PTR_W-1:0] wr_addr,
  input wire logic [dif_pkg::DIF_BUS_W-1:0] wr_data,
  input wire logic [dif_pkg::DIF_PTR_W-1:0] rd_addr,
  output logic [dif_pkg::DIF_BUS_W-1:0] rd_data
);
  import dif_pkg::*;

  typedef struct packed {
    logic [DIF_DEPTH-1:0][DIF_BUS_W-1:0] mem;
    logic [DIF_BUS_W-1:0] rd;
  } dif_store_t;

  dif_store_t st;
  dif_store_t next_st;

  // ==========================================================
  // Storage
  always_comb begin
    next_st = st;
    if (wr_en) begin
      next_st.mem[wr_addr] = wr_data;
    end
    // Read of the entry being written returns old data, as equal pointers must be avoided
    next_st.rd = st.mem[rd_addr];
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign rd_data = st.rd;

endmodule

`default_nettype wire

// *** verilog/dif_top.sv ***
// Input elastic buffer: strobe-port capture, pointers, level init and status.
// Assumes strobe, conversion clock and sync are slow enough to be sampled by clk.
`default_nettype none

module dif_top (
  input wire logic clk,
  input wire logic resetn,
  input wire logic data_strobe_clock,
  input wire logic [dif_pkg::DIF_BUS_W-1:0] data_bus,
  input wire logic channel_marker,
  input wire logic [1:0] bus_mode,
  input wire logic conversion_clock,
  input wire logic [1:0] interp_sel,
  input wire logic reference_sync_input,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic [dif_pkg::DIF_WORD_W-1:0] i_out,
  output logic [dif_pkg::DIF_WORD_W-1:0] q_out,
  output logic out_valid,
  output logic fifo_warning
);
  import dif_pkg::*;

  typedef struct packed {
    logic strobe_prev;
    logic conv_prev;
    logic [DIF_PTR_W-1:0] wp;
    logic [DIF_PTR_W-1:0] rp;
    logic [2:0] div_cnt;
    logic [7:0] byte_hi;
    logic byte_half;
    logic [DIF_WORD_W-1:0] i_hold;
    logic [2:0] mark_cnt;
    logic mark_done;
    logic rel_pend;
    logic pend_marker;
    logic req;
    logic init_ok;
    logic by_marker;
    logic by_serial;
    logic [7:0] sync_ctl;
    logic [2:0] offset;
    logic [7:0] rdata;
    logic fetch;
    logic [DIF_WORD_W-1:0] i_out;
    logic [DIF_WORD_W-1:0] q_out;
    logic out_valid;
    logic warn;
  } dif_state_t;

  dif_state_t st;
  dif_state_t next_st;

  logic mem_we;
  logic [DIF_PTR_W-1:0] mem_waddr;
  logic [DIF_BUS_W-1:0] mem_wdata;
  logic [DIF_BUS_W-1:0] mem_rdata;

  // ==========================================================
  // Helpers
  function automatic logic [2:0] load_len(input logic [1:0] mode);
    unique case (mode)
      DIF_MODE_DUAL: load_len = DIF_LOAD_DUAL;
      DIF_MODE_WORD: load_len = DIF_LOAD_WORD;
      default: load_len = DIF_LOAD_BYTE;
    endcase
  endfunction

  function automatic logic [2:0] interp_last(input logic [1:0] sel);
    unique case (sel)
      DIF_INTERP_1: interp_last = 3'h0;
      DIF_INTERP_2: interp_last = 3'h1;
      DIF_INTERP_4: interp_last = 3'h3;
      default: interp_last = 3'h7;
    endcase
  endfunction

  function automatic logic [6:0] thermo(input logic [DIF_PTR_W-1:0] lvl);
    logic [6:0] t;
    t = 7'h00;
    for (int k = 0; k < 7; k++) begin
      t[k] = (3'(k) < lvl);
    end
    thermo = t;
  endfunction

  // ==========================================================
  // Storage
  dif_store u_store (
    .clk(clk),
    .resetn(resetn),
    .wr_en(mem_we),
    .wr_addr(mem_waddr),
    .wr_data(mem_wdata),
    .rd_addr(st.rp),
    .rd_data(mem_rdata)
  );

  // ==========================================================
  // Next-state logic
  logic strobe_fall;
  logic conv_rise;
  logic conv_edge;
  logic rate_tick;
  logic sync_en;
  logic rate_mode;
  logic sync_hit;
  logic serial_trig;
  logic marker_full;
  logic [DIF_PTR_W-1:0] level;
  logic [DIF_PTR_W-1:0] next_level;

  always_comb begin
    next_st = st;
    mem_we = 1'b0;
    mem_waddr = st.wp;
    mem_wdata = '0;
    next_st.strobe_prev = data_strobe_clock;
    next_st.conv_prev = conversion_clock;
    next_st.out_valid = 1'b0;
    sync_en = st.sync_ctl[DIF_SYNC_EN_BIT];
    rate_mode = st.sync_ctl[DIF_SYNC_MODE_BIT];
    serial_trig = 1'b0;
    marker_full = 1'b0;

    strobe_fall = st.strobe_prev && !data_strobe_clock;
    conv_rise = !st.conv_prev && conversion_clock;
    conv_edge = st.sync_ctl[DIF_SYNC_EDGE_BIT] ? (st.conv_prev && !conversion_clock)
                                                 : conv_rise;
    // sync acts only in FIFO-rate mode
    sync_hit = sync_en && !rate_mode && conv_edge && reference_sync_input;

    // ==========================================================
    // Capture and write
    if (strobe_fall) begin
      // count strobes with marker held high
      if (channel_marker) begin
        if (st.mark_cnt != load_len(bus_mode)) begin
          next_st.mark_cnt = st.mark_cnt + 3'h1;
          marker_full = (st.mark_cnt + 3'h1 == load_len(bus_mode));
        end
      end else begin
        next_st.mark_cnt = 3'h0;
      end
      unique case (bus_mode)
        DIF_MODE_DUAL: begin
          mem_we = 1'b1;
          mem_wdata = data_bus;
        end
        DIF_MODE_WORD: begin
          if (channel_marker) begin
            next_st.i_hold = data_bus[DIF_WORD_W-1:0];
          end else begin
            mem_we = 1'b1;
            mem_wdata = {st.i_hold, data_bus[DIF_WORD_W-1:0]};
          end
        end
        default: begin
          // High byte first; a marker change restarts the pairing
          if (!st.byte_half || (st.mark_cnt != 3'h0) != channel_marker) begin
            next_st.byte_hi = data_bus[7:0];
            next_st.byte_half = 1'b1;
          end else begin
            next_st.byte_half = 1'b0;
            if (channel_marker) begin
              next_st.i_hold = {st.byte_hi, data_bus[7:0]};
            end else begin
              mem_we = 1'b1;
              mem_wdata = {st.i_hold, st.byte_hi, data_bus[7:0]};
            end
          end
        end
      endcase
    end

    if (mem_we) begin
      next_st.wp = st.wp + 3'h1;
    end

    // ==========================================================
    // Read side
    rate_tick = 1'b0;
    if (conv_rise) begin
      if (st.div_cnt >= interp_last(interp_sel)) begin
        next_st.div_cnt = 3'h0;
        rate_tick = 1'b1;
      end else begin
        next_st.div_cnt = st.div_cnt + 3'h1;
      end
    end
    next_st.fetch = rate_tick;
    if (rate_tick) begin
      next_st.rp = st.rp + 3'h1;
    end
    if (st.fetch) begin
      next_st.i_out = mem_rdata[DIF_BUS_W-1:DIF_WORD_W];
      next_st.q_out = mem_rdata[DIF_WORD_W-1:0];
      next_st.out_valid = 1'b1;
    end
    // sync clears read pointer and rate phase
    if (sync_hit) begin
      next_st.rp = '0;
      next_st.div_cnt = 3'h0;
    end

    // ==========================================================
    // Pointer initialisation
    if (marker_full) begin
      next_st.init_ok = 1'b0;
      next_st.by_marker = 1'b1;
      next_st.by_serial = 1'b0;
      if (sync_en && !rate_mode) begin
        next_st.wp = st.offset;
        next_st.init_ok = 1'b1;
        next_st.rel_pend = 1'b0;
      end else begin
        // start level at next read zero
        next_st.rel_pend = 1'b1;
        next_st.pend_marker = 1'b1;
      end
    end

    // ==========================================================
    // Register writes
    if (reg_wr) begin
      unique case (reg_addr)
        DIF_ADDR_SYNC_CONTROL: next_st.sync_ctl = reg_wdata;
        DIF_ADDR_PHASE_OFFSET: next_st.offset = reg_wdata[2:0];
        DIF_ADDR_INIT_STATUS: begin
          next_st.req = reg_wdata[DIF_ST_REQ_BIT];
          serial_trig = reg_wdata[DIF_ST_REQ_BIT] && !st.req;
        end
        default: ;
      endcase
    end
    if (serial_trig) begin
      next_st.rel_pend = 1'b1;
      next_st.pend_marker = 1'b0;
      next_st.init_ok = 1'b0;
      next_st.by_serial = 1'b1;
      next_st.by_marker = 1'b0;
    end

    // load offset when read pointer is zero
    // Load wins over a write in the same cycle
    if (st.rel_pend && st.rp == '0 && !serial_trig && !marker_full) begin
      next_st.wp = st.offset;
      next_st.rel_pend = 1'b0;
      next_st.init_ok = 1'b1;
    end

    // ==========================================================
    // Status and readback
    level = st.wp - st.rp;
    next_level = next_st.wp - next_st.rp;
    // warn at level 1 or 7
    next_st.warn = (next_level == DIF_LEVEL_LOW) || (next_level == DIF_LEVEL_HIGH);
    if (reg_rd) begin
      unique case (reg_addr)
        DIF_ADDR_SYNC_CONTROL: next_st.rdata = st.sync_ctl;
        DIF_ADDR_PHASE_OFFSET: next_st.rdata = {5'h00, st.offset};
        DIF_ADDR_INIT_STATUS: begin
          next_st.rdata = 8'h00;
          next_st.rdata[DIF_ST_OK_BIT] = st.init_ok;
          next_st.rdata[DIF_ST_REQ_BIT] = st.req;
          next_st.rdata[DIF_ST_ACK_BIT] = st.req;
          next_st.rdata[DIF_ST_BY_MARKER_BIT] = st.by_marker;
          next_st.rdata[DIF_ST_BY_SERIAL_BIT] = st.by_serial;
          next_st.rdata[DIF_ST_WARN_BIT] = st.warn;
        end
        DIF_ADDR_LEVEL: next_st.rdata = {1'b0, thermo(level)};
        default: next_st.rdata = 8'h00;
      endcase
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge clk) begin
    if (!resetn) begin
      st <= '0;
      st.sync_ctl <= DIF_SYNC_CONTROL_RST;
      st.offset <= DIF_PHASE_OFFSET_RST;
    end else begin
      st <= next_st;
    end
  end

  assign reg_rdata = st.rdata;
  assign i_out = st.i_out;
  assign q_out = st.q_out;
  assign out_valid = st.out_valid;
  assign fifo_warning = st.warn;

endmodule

`default_nettype wire
